//--- design/io_cmd_pkg.sv
// shared constants and types for the cpu to channel instruction handshake
package io_cmd_pkg;
  localparam int WORD_W = 24;
  // instruction field layout
  localparam int UNIT_LO = 0;
  localparam int UNIT_W = 4;
  localparam int MODE_LO = 4;
  localparam int MODE_W = 2;
  localparam int CHAN_LO = 6;
  localparam int CHAN_W = 5;
  localparam int OVR_BIT = 11;
  localparam int OPC_LO = 12;
  localparam int OPC_W = 12;
  // condition register zero flag position
  localparam int COND_ZERO_BIT = 2;
  localparam int COND_W = 4;
  // modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_MULTIPLEX = 2'h1;
  localparam logic [1:0] MODE_OFFLINE = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h3;
  // reserved channel number, octal 30
  localparam logic [4:0] CHAN_FORBIDDEN = 5'h18;
  // only unit accepted by a dma processor channel, octal 10
  localparam logic [3:0] DMA_UNIT = 4'h8;
  // disconnect/connect length in cycles
  localparam int SWITCH_CYCLES = 2;
  localparam logic [1:0] SWITCH_LAST = 2'(SWITCH_CYCLES - 1);
  // status word fields
  localparam int STAT_UNIT_W = 8;
  localparam int STAT_BUSY_BIT = 23;
  // instruction kinds
  typedef enum logic [1:0] {
    KIND_CMD  = 2'h0,
    KIND_STAT = 2'h1,
    KIND_DATA = 2'h2
  } io_kind_t;
  // channel types
  typedef enum logic [1:0] {
    CHT_UNIVERSAL   = 2'h0,
    CHT_EXTENDED    = 2'h1,
    CHT_INTERLEAVED = 2'h2,
    CHT_DMA_PROC    = 2'h3
  } chan_type_t;
endpackage : io_cmd_pkg

//--- design/io_chan_if.sv
// interface joining cpu instruction logic and one i/o channel
`timescale 1ns/1ps
interface io_chan_if;
  logic                 req;      // one-cycle instruction strobe
  io_cmd_pkg::io_kind_t kind;
  logic [23:0]          instr;    // instruction word
  logic [23:0]          wdata;    // accumulator contents
  logic                 accept;   // same-cycle channel acceptance
  logic [23:0]          rdata;    // status word when accepted
  modport cpu  (output req, output kind, output instr, output wdata,
                input accept, input rdata);
  modport chan (input req, input kind, input instr, input wdata,
                output accept, output rdata);
endinterface : io_chan_if

//--- design/io_cpu_end.sv
// cpu end: issues i/o instructions and keeps the zero/not zero condition bit
`timescale 1ns/1ps
module io_cpu_end (
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  // instruction request from the sequencer
  input  wire logic                 issue_in,
  input  wire io_cmd_pkg::io_kind_t kind_in,
  input  wire logic [23:0]          instr_in,
  input  wire logic [23:0]          acc_in,
  input  wire logic                 wide_cmd_in,
  // results
  output logic [3:0]                cond_out,
  output logic [23:0]               status_out,
  output logic                      done_out,
  // decoded fields of the last instruction
  output logic [3:0]                unit_out,
  output logic [1:0]                mode_out,
  output logic [4:0]                chan_out,
  output logic                      ovr_out,
  output logic [11:0]               opcode_out,
  // channel side
  io_chan_if.cpu                    chan
);
  typedef struct packed {
    logic [3:0]  cond;
    logic [23:0] status;
    logic        done;
    logic [3:0]  unit;
    logic [1:0]  mode;
    logic [4:0]  chan;
    logic        ovr;
    logic [11:0] opc;
  } cpu_state_t;

  cpu_state_t cur_ff;
  cpu_state_t nxt_cur;

  // request goes out in the issue cycle; the answer is sampled same cycle
  assign chan.req   = issue_in;
  assign chan.kind  = kind_in;
  assign chan.instr = instr_in;
  // short command words keep only the low byte of the accumulator
  assign chan.wdata = (kind_in == io_cmd_pkg::KIND_CMD && !wide_cmd_in)
                      ? {16'h0000, acc_in[7:0]} : acc_in;

  // one cycle per instruction, no hold inserted
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    if (issue_in) begin
      nxt_cur.done = 1'b1;
      nxt_cur.cond = 4'h0;
      // zero flag reflects acceptance only, not unit completion
      nxt_cur.cond[io_cmd_pkg::COND_ZERO_BIT] = chan.accept;
      if (chan.accept && kind_in == io_cmd_pkg::KIND_STAT) begin
        nxt_cur.status = chan.rdata;
      end
      nxt_cur.unit = instr_in[io_cmd_pkg::UNIT_LO +: io_cmd_pkg::UNIT_W];
      nxt_cur.mode = instr_in[io_cmd_pkg::MODE_LO +: io_cmd_pkg::MODE_W];
      nxt_cur.chan = instr_in[io_cmd_pkg::CHAN_LO +: io_cmd_pkg::CHAN_W];
      nxt_cur.ovr  = instr_in[io_cmd_pkg::OVR_BIT];
      nxt_cur.opc  = instr_in[io_cmd_pkg::OPC_LO +: io_cmd_pkg::OPC_W];
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cond_out   = cur_ff.cond;
  assign status_out = cur_ff.status;
  assign done_out   = cur_ff.done;
  assign unit_out   = cur_ff.unit;
  assign mode_out   = cur_ff.mode;
  assign chan_out   = cur_ff.chan;
  assign ovr_out    = cur_ff.ovr;
  assign opcode_out = cur_ff.opc;
endmodule : io_cpu_end

//--- design/io_channel_end.sv
// channel end: accepts or refuses instructions, switches units, forwards commands
//
// Contract
// - instruction never waits on channel response
// - clear to not zero, zero if accepted
// - zero means accepted, not operation finished
// - missing channel or unit stays not zero
// - channel number octal 30 never assigned
// - other unit: not ready two switch cycles
// - mode bits choose normal or multiplex
// - block and dma channels ignore multiplex (code: refused on all but universal, which sets multiplex)
// - offline is multiplex plus drivers off
// - reset mode returns channel on-line
// - command word carries eight or 24 bits
// - decode unit, mode, channel, override, opcode
// - dma channel accepts only unit octal 10
// - override takes command, switches, reports zero
// - dma override clears channel, halts processor (code only sets the halt; channel state and unit are kept)
// - other unit accepted not ready, then forwarded
// - not ready until unit takes data
// - block override stops; else ignored till count
// - status during command refused till accepted
// - status to other unit refused, switches unit
// - block status returns unit and busy bits
// - status while receiving data is accepted
`timescale 1ns/1ps
module io_channel_end (
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_in,
  // channel configuration
  input  wire logic [4:0]             my_chan_in,
  input  wire io_cmd_pkg::chan_type_t chan_type_in,
  input  wire logic [15:0]            units_present_in,
  // peripheral unit side
  input  wire logic                   unit_take_in,
  input  wire logic [7:0]             unit_status_in,
  input  wire logic                   block_busy_in,
  input  wire logic                   unit_rx_data_in,
  output logic                        unit_cmd_valid_out,
  output logic [23:0]                 unit_cmd_out,
  output logic [3:0]                  unit_sel_out,
  output logic                        block_stop_out,
  output logic                        proc_halt_out,
  output logic                        drivers_on_out,
  output logic                        multiplex_out,
  // cpu side
  io_chan_if.chan                     cpu
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SWITCH = 2'h1,
    ST_SEND   = 2'h3,
    ST_DEAD   = 2'h2
  } ch_state_t;

  typedef struct packed {
    ch_state_t   st;
    logic [1:0]  cnt;
    logic [3:0]  unit;
    logic        pend;
    logic [23:0] cmd;
    logic        stop;
    logic        halt;
    logic        drv;
    logic        mux;
  } ch_reg_t;

  ch_reg_t cur_ff;
  ch_reg_t nxt_cur;

  logic       sel;
  logic [3:0] u;
  logic       ovr;
  logic       same;
  logic       is_dma;
  logic       is_blk;
  logic       acc;

  // decode of the presented instruction
  always_comb begin
    u      = cpu.instr[io_cmd_pkg::UNIT_LO +: io_cmd_pkg::UNIT_W];
    ovr    = cpu.instr[io_cmd_pkg::OVR_BIT];
    // octal 30 is never a valid channel address
    sel    = cpu.req && cpu.instr[io_cmd_pkg::CHAN_LO +: io_cmd_pkg::CHAN_W] == my_chan_in
             && my_chan_in != io_cmd_pkg::CHAN_FORBIDDEN;
    same   = (u == cur_ff.unit);
    is_dma = (chan_type_in == io_cmd_pkg::CHT_DMA_PROC);
    // only a universal block channel refuses plain commands mid-block
    is_blk = (chan_type_in == io_cmd_pkg::CHT_UNIVERSAL) && block_busy_in;
  end

  // acceptance and state update
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.stop = 1'b0;
    acc          = 1'b0;
    case (cur_ff.st)
      ST_SWITCH: begin
        // disconnect/connect holds the channel not ready
        if (cur_ff.cnt == io_cmd_pkg::SWITCH_LAST) begin
          nxt_cur.st = cur_ff.pend ? ST_SEND : ST_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + 2'h1;
        end
      end
      ST_SEND: begin
        // not ready until the unit takes the word
        if (unit_take_in) begin
          nxt_cur.pend = 1'b0;
          nxt_cur.st   = ST_IDLE;
        end
      end
      ST_DEAD: begin
        // only reset leaves this state
        nxt_cur.st = ST_DEAD;
      end
      ST_IDLE: begin
        if (sel && (is_dma && u != io_cmd_pkg::DMA_UNIT
                    || !units_present_in[u])) begin
          // taken but never answered ready again
          nxt_cur.st = ST_DEAD;
        end else if (sel && cpu.kind == io_cmd_pkg::KIND_CMD) begin
          // dma override halts the processor and never reports zero
          if (ovr && is_dma) begin
            nxt_cur.halt = 1'b1;
          end else if (ovr) begin
            // taken at once; switches even when the unit is already connected
            acc          = 1'b1;
            nxt_cur.stop = is_blk;
            nxt_cur.cmd  = cpu.wdata;
            nxt_cur.pend = 1'b1;
            nxt_cur.unit = u;
            nxt_cur.cnt  = 2'h0;
            nxt_cur.st   = ST_SWITCH;
          end else if (!is_blk) begin
            if (cpu.instr[io_cmd_pkg::MODE_LO +: io_cmd_pkg::MODE_W]
                == io_cmd_pkg::MODE_MULTIPLEX && chan_type_in != io_cmd_pkg::CHT_UNIVERSAL) begin
              acc = 1'b0;
            end else begin
              // another unit: word kept and sent after the switch, not zero now
              acc          = same;
              nxt_cur.cmd  = cpu.wdata;
              nxt_cur.pend = 1'b1;
              nxt_cur.unit = u;
              nxt_cur.cnt  = 2'h0;
              nxt_cur.st   = same ? ST_SEND : ST_SWITCH;
              case (cpu.instr[io_cmd_pkg::MODE_LO +: io_cmd_pkg::MODE_W])
                io_cmd_pkg::MODE_MULTIPLEX: begin
                  nxt_cur.mux = 1'b1;
                end
                io_cmd_pkg::MODE_OFFLINE: begin
                  nxt_cur.mux = 1'b1;
                  nxt_cur.drv = 1'b0;
                end
                io_cmd_pkg::MODE_RESET: begin
                  nxt_cur.mux = 1'b0;
                  nxt_cur.drv = 1'b1;
                end
                default: begin
                end
              endcase
            end
          end
        end else if (sel) begin
          // status or data request
          if (!same) begin
            nxt_cur.unit = u;
            nxt_cur.cnt  = 2'h0;
            nxt_cur.st   = ST_SWITCH;
          end else begin
            // a unit still taking output data refuses a new data word, never status
            acc = cpu.kind == io_cmd_pkg::KIND_STAT
                  || !is_blk && !unit_rx_data_in;
          end
        end
      end
      default: begin
        nxt_cur.st = ST_IDLE;
      end
    endcase
  end

  // combinational answer, so the cpu never waits a cycle
  assign cpu.accept = acc;
  // status word: unit status low byte, block busy in the top bit
  assign cpu.rdata  = {block_busy_in, 15'h0000, unit_status_in};

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      // idle on unit zero with the bus drivers on
      cur_ff     <= '0;
      cur_ff.drv <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // every unit-side output straight from the state register
  assign unit_cmd_valid_out = (cur_ff.st == ST_SEND);
  assign unit_cmd_out       = cur_ff.cmd;
  assign unit_sel_out       = cur_ff.unit;
  assign block_stop_out     = cur_ff.stop;
  assign proc_halt_out      = cur_ff.halt;
  assign drivers_on_out     = cur_ff.drv;
  assign multiplex_out      = cur_ff.mux;
endmodule : io_channel_end

//--- test/io_handshake_asserts.sv
// concurrent checks on the signals between cpu end and channel end
`timescale 1ns/1ps
module io_handshake_asserts #(
  parameter logic [4:0] CHAN = 5'h01
) (
  // clock and reset
  input wire logic                 core_clk_in,
  input wire logic                 reset_in,
  // link signals
  input wire logic                 req,
  input wire io_cmd_pkg::io_kind_t kind,
  input wire logic [23:0]          instr,
  input wire logic [23:0]          wdata,
  input wire logic                 accept,
  input wire logic [23:0]          rdata
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // an accepted command, the cause of most busy periods
  logic acc_cmd;
  assign acc_cmd = req && accept && kind == io_cmd_pkg::KIND_CMD;

  a_accept_needs_req: assert property (accept |-> req)
    else $error("accept seen without a request");
  a_fresh_status: assert property ($past(reset_in) && req && kind == io_cmd_pkg::KIND_STAT
    && instr[10:6] == CHAN && instr[3:0] == 4'h0 |-> accept)
    else $error("idle channel refused status for unit zero after reset");
  a_forbidden_chan: assert property (req && instr[10:6] == 5'h18 |-> !accept)
    else $error("reserved channel number accepted");
  a_wrong_chan: assert property (req && instr[10:6] != CHAN |-> !accept)
    else $error("request for another channel accepted");
  a_cmd_then_busy: assert property (acc_cmd |=> !accept)
    else $error("channel accepted again before unit took command");
  a_stat_after_cmd: assert property (acc_cmd ##1 (req && kind == io_cmd_pkg::KIND_STAT)
    |-> !accept)
    else $error("status accepted while command pending");
  a_ovr_switch: assert property (acc_cmd && instr[11] |=> !accept [*2])
    else $error("override did not hold channel for the switch");
  a_stat_word: assert property (req && accept && kind == io_cmd_pkg::KIND_STAT
    |-> rdata[22:8] == 15'h0)
    else $error("status word middle bits not zero");
endmodule : io_handshake_asserts

//--- test/test_io_channel_command_handshake.sv
// self-checking bench for the cpu end and channel end handshake
`timescale 1ns/1ps
module test_io_channel_command_handshake;
  typedef struct packed {
    logic [1:0]  kind;
    logic        ovr;
    logic [1:0]  mode;
    logic [3:0]  unit;
    logic [23:0] acc;
    logic [4:0]  ex;  // wide, zero, forwarded, multiplex, drivers on
  } row_t;
  localparam logic [4:0] MY_CHAN = 5'h01;
  localparam logic [7:0] USTAT   = 8'h5a;
  logic clk = 1'b0, rst = 1'b1, issue = 1'b0, wide = 1'b0, take_in = 1'b0, busy = 1'b0;
  io_cmd_pkg::io_kind_t   kind  = io_cmd_pkg::KIND_CMD;
  io_cmd_pkg::chan_type_t ctype = io_cmd_pkg::CHT_UNIVERSAL;
  logic [23:0] instr = 24'h0, acc = 24'h0, status, ucmd;
  logic [3:0]  cond, unit_o, usel;
  logic [1:0]  mode_o;
  logic [4:0]  chan_o;
  logic [11:0] opc_o;
  logic        done, ovr_o, uvalid, stop, halt, drv_on, mux_o, stop_seen = 1'b0, rx = 1'b0;
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  row_t        rows[10];

  // 4 ns clock
  always #2 clk = ~clk;

  io_chan_if link();
  io_cpu_end u_io_cpu_end (.core_clk_in(clk), .reset_in(rst), .issue_in(issue), .kind_in(kind),
    .instr_in(instr), .acc_in(acc), .wide_cmd_in(wide), .cond_out(cond), .status_out(status),
    .done_out(done), .unit_out(unit_o), .mode_out(mode_o), .chan_out(chan_o), .ovr_out(ovr_o),
    .opcode_out(opc_o), .chan(link.cpu));
  io_channel_end u_io_channel_end (.core_clk_in(clk), .reset_in(rst), .my_chan_in(MY_CHAN),
    .chan_type_in(ctype), .units_present_in(16'h7fff), .unit_take_in(take_in),
    .unit_status_in(USTAT), .block_busy_in(busy), .unit_rx_data_in(rx),
    .unit_cmd_valid_out(uvalid), .unit_cmd_out(ucmd), .unit_sel_out(usel),
    .block_stop_out(stop), .proc_halt_out(halt), .drivers_on_out(drv_on),
    .multiplex_out(mux_o), .cpu(link.chan));
  io_handshake_asserts #(.CHAN(MY_CHAN)) u_io_handshake_asserts (.core_clk_in(clk),
    .reset_in(rst), .req(link.req), .kind(link.kind), .instr(link.instr),
    .wdata(link.wdata), .accept(link.accept), .rdata(link.rdata));

  // cycle ceiling; also latch the stop pulse, which may fall between our sample points
  always @(posedge clk) begin
    cyc++;
    if (stop === 1'b1) stop_seen = 1'b1;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end

  function automatic logic [23:0] mk(input logic o, input logic [1:0] m, input logic [3:0] u,
                                     input logic [4:0] ch = MY_CHAN);
    return {12'ha51, o, ch, m, u};
  endfunction : mk

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one instruction strobe, left high for a back-to-back request; idle and take drop it
  task automatic io(input logic [1:0] k, input logic [23:0] i, input logic [23:0] a,
                    input logic w, input logic z);
    kind  = io_cmd_pkg::io_kind_t'(k);
    instr = i;
    acc   = a;
    wide  = w;
    issue = 1'b1;
    @(posedge clk);
    #1;
    chk({22'h0, done, cond[2]}, {22'h0, 1'b1, z});
  endtask : io

  // wait for the forwarded command, then let the unit take it
  task automatic take(input logic [23:0] c, input logic [3:0] u, input int w);
    int n;
    issue = 1'b0;
    n = 0;
    while (uvalid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    chk(24'(uvalid), 24'h1);
    chk(24'(n), 24'(w));
    chk(ucmd, c);
    chk(24'(usel), 24'(u));
    take_in = 1'b1;
    @(posedge clk);
    #1 take_in = 1'b0;
    chk(24'(uvalid), 24'h0);
  endtask : take

  task automatic idle();
    issue = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : idle

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // main sequence: table rows, then hand-written awkward cases
  initial begin
    logic [23:0] ins;
    rows = '{'{2'h1, 1'b0, 2'h0, 4'h0, 24'h0, 5'h09}, '{2'h0, 1'b0, 2'h0, 4'h0, 24'habcdef, 5'h1d},
             '{2'h0, 1'b0, 2'h0, 4'h0, 24'h123456, 5'h0d}, '{2'h0, 1'b0, 2'h0, 4'h3, 24'h11, 5'h15},
             '{2'h1, 1'b0, 2'h0, 4'h5, 24'h0, 5'h01}, '{2'h1, 1'b0, 2'h0, 4'h5, 24'h0, 5'h09},
             '{2'h0, 1'b0, 2'h1, 4'h5, 24'h33, 5'h1f}, '{2'h0, 1'b0, 2'h2, 4'h5, 24'h44, 5'h1e},
             '{2'h0, 1'b0, 2'h3, 4'h5, 24'h55, 5'h1d}, '{2'h0, 1'b1, 2'h0, 4'h7, 24'h66, 5'h1d}};
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[r]) begin
      ins = mk(rows[r].ovr, rows[r].mode, rows[r].unit);
      io(rows[r].kind, ins, rows[r].acc, rows[r].ex[4], rows[r].ex[3]);
      chk({opc_o, ovr_o, chan_o, mode_o, unit_o}, ins);
      if (rows[r].kind == 2'h1 && rows[r].ex[3])
        chk(status, {16'h0, USTAT});
      if (rows[r].ex[2])
        take(rows[r].ex[4] ? rows[r].acc : {16'h0, rows[r].acc[7:0]}, rows[r].unit,
             (rows[r].ovr || !rows[r].ex[3]) ? io_cmd_pkg::SWITCH_CYCLES : 0);
      chk({22'h0, mux_o, drv_on}, {22'h0, rows[r].ex[1:0]});
      idle();
    end
    $display("test table rows done");
    io(2'h0, mk(1'b0, 2'h0, 4'h7), 24'h22, 1'b1, 1'b1);
    io(2'h1, mk(1'b0, 2'h0, 4'h7), 24'h0, 1'b0, 1'b0);
    take(24'h22, 4'h7, 0);
    io(2'h1, mk(1'b0, 2'h0, 4'h7), 24'h0, 1'b0, 1'b1);
    $display("test pending command done");
    busy = 1'b1;
    io(2'h0, mk(1'b0, 2'h0, 4'h7), 24'h77, 1'b1, 1'b0);
    io(2'h1, mk(1'b0, 2'h0, 4'h7), 24'h0, 1'b0, 1'b1);
    chk(status, {1'b1, 15'h0, USTAT});
    io(2'h0, mk(1'b1, 2'h0, 4'h7), 24'h88, 1'b1, 1'b1);
    take(24'h88, 4'h7, io_cmd_pkg::SWITCH_CYCLES);
    chk(24'(stop_seen), 24'h1);
    busy = 1'b0;
    io(2'h0, mk(1'b0, 2'h0, 4'h7, 5'h18), 24'h1, 1'b1, 1'b0);
    io(2'h1, mk(1'b0, 2'h0, 4'h7, 5'h02), 24'h0, 1'b0, 1'b0);
    $display("test block and channel select done");
    rx = 1'b1;
    io(2'h2, mk(1'b0, 2'h0, 4'h7), 24'h9, 1'b1, 1'b0);
    io(2'h1, mk(1'b0, 2'h0, 4'h7), 24'h0, 1'b0, 1'b1);
    chk(status, {16'h0, USTAT});
    rx = 1'b0;
    io(2'h2, mk(1'b0, 2'h0, 4'h7), 24'h9, 1'b1, 1'b1);
    $display("test data and status while receiving done");
    ctype = io_cmd_pkg::CHT_DMA_PROC;
    io(2'h0, mk(1'b0, 2'h1, 4'h8), 24'h1, 1'b1, 1'b0);
    idle();
    io(2'h0, mk(1'b1, 2'h0, 4'h8), 24'h1, 1'b1, 1'b0);
    idle();
    chk(24'(halt), 24'h1);
    io(2'h0, mk(1'b0, 2'h0, 4'h3), 24'h1, 1'b1, 1'b0);
    idle();
    io(2'h0, mk(1'b0, 2'h0, 4'h8), 24'h1, 1'b1, 1'b0);
    $display("test dma channel done");
    ctype = io_cmd_pkg::CHT_UNIVERSAL;
    issue = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk({20'h0, cond}, 24'h0);
    chk({21'h0, halt, mux_o, drv_on}, 24'h1);
    io(2'h1, mk(1'b0, 2'h0, 4'h0), 24'h0, 1'b0, 1'b1);
    io(2'h0, mk(1'b0, 2'h0, 4'hf), 24'h1, 1'b1, 1'b0);
    idle();
    io(2'h1, mk(1'b0, 2'h0, 4'h0), 24'h0, 1'b0, 1'b0);
    $display("test reset and absent unit done");
    close_out();
  end
endmodule : test_io_channel_command_handshake
